// ==== hw/camd_consts.vh ====
/*
  Constants for the addressing-mode decoder: prebyte codes, mode codes,
  group codes, fetch states, sizes and low-power codes.
  Assumes inclusion by bare name from the decoder modules.
*/
`ifndef CAMD_CONSTS_VH
`define CAMD_CONSTS_VH

// ==========================================================
// prebytes
`define CAMD_PRE_SECOND_INDEX 8'h90
`define CAMD_PRE_INDIRECT 8'h92
`define CAMD_PRE_SECOND_INDIRECT 8'h91

// ==========================================================
// addressing modes (4 bits)
`define CAMD_M_INH 4'h0
`define CAMD_M_IMM 4'h1
`define CAMD_M_DIR_S 4'h2
`define CAMD_M_DIR_L 4'h3
`define CAMD_M_IDX_0 4'h4
`define CAMD_M_IDX_S 4'h5
`define CAMD_M_IDX_L 4'h6
`define CAMD_M_IND_S 4'h7
`define CAMD_M_IND_L 4'h8
`define CAMD_M_IIX_S 4'h9
`define CAMD_M_IIX_L 4'hA
`define CAMD_M_REL_D 4'hB
`define CAMD_M_REL_I 4'hC
`define CAMD_M_BAD 4'hF

// ==========================================================
// instruction groups (4 bits), thirteen of them
`define CAMD_G_LOAD 4'h0
`define CAMD_G_STACK 4'h1
`define CAMD_G_INCDEC 4'h2
`define CAMD_G_CMP 4'h3
`define CAMD_G_LOGIC 4'h4
`define CAMD_G_BIT 4'h5
`define CAMD_G_BTJ 4'h6
`define CAMD_G_ARITH 4'h7
`define CAMD_G_SHIFT 4'h8
`define CAMD_G_JUMP 4'h9
`define CAMD_G_COND 4'hA
`define CAMD_G_INT 4'hB
`define CAMD_G_FLAG 4'hC
`define CAMD_GROUP_COUNT 13
`define CAMD_INSN_COUNT 63

// ==========================================================
// fetch states
`define CAMD_S_OPC 3'h0
`define CAMD_S_OP1 3'h1
`define CAMD_S_OP2 3'h2
`define CAMD_S_PTR1 3'h3
`define CAMD_S_PTR2 3'h4
`define CAMD_S_DONE 3'h5

// ==========================================================
// sizes and low-power codes
`define CAMD_MAX_LEN 3'h4
`define CAMD_LOW_POWER_NONE 2'h0
`define CAMD_LOW_POWER_WAIT 2'h1
`define CAMD_LOW_POWER_HALT 2'h2

`endif

// ==== hw/camd_opcode_table.v ====
/*
  Opcode classifier: maps one opcode byte to its base addressing mode,
  group, short-only flag and legality.
  Assumes a pure combinational use from the decoder on the same clock.
  The encoding is a regular map of our own: high nibble picks the mode
  column, low nibble picks the operation.
*/
`timescale 1ns/1ps
`default_nettype none
`include "camd_consts.vh"

module camd_opcode_table (
  // opcode in
  input wire [7:0] opcode,
  // classification out
  output reg [3:0] base_mode,
  output reg [3:0] group,
  output reg short_only,
  output reg is_wait,
  output reg is_halt,
  output reg legal
);

  wire [3:0] col = opcode[7:4];
  wire [3:0] op = opcode[3:0];

  // ==========================================================
  // mode by column
  always @* begin
    legal = 1'b1;
    case (col)
      4'h0: base_mode = `CAMD_M_INH;
      4'h1: base_mode = `CAMD_M_IMM;
      4'h2: base_mode = `CAMD_M_DIR_S;
      4'h3: base_mode = `CAMD_M_DIR_L;
      4'h4: base_mode = `CAMD_M_IDX_0;
      4'h5: base_mode = `CAMD_M_IDX_S;
      4'h6: base_mode = `CAMD_M_IDX_L;
      4'h7: base_mode = `CAMD_M_REL_D;
      default: begin
        base_mode = `CAMD_M_BAD;
        legal = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // group and short-only flag by operation
  always @* begin
    short_only = 1'b0;
    is_wait = 1'b0;
    is_halt = 1'b0;
    case (op)
      4'h0: group = `CAMD_G_LOAD;
      4'h1: group = `CAMD_G_CMP;
      4'h2: group = `CAMD_G_LOGIC;
      4'h3: group = `CAMD_G_ARITH;
      4'h4: begin
        group = `CAMD_G_INCDEC;
        short_only = 1'b1;
      end
      4'h5: begin
        group = `CAMD_G_BIT;
        short_only = 1'b1;
      end
      4'h6: begin
        group = `CAMD_G_BTJ;
        short_only = 1'b1;
      end
      4'h7: begin
        group = `CAMD_G_SHIFT;
        short_only = 1'b1;
      end
      4'h8: begin
        group = `CAMD_G_JUMP;
        short_only = 1'b1;
      end
      4'h9: group = `CAMD_G_COND;
      4'hA: group = `CAMD_G_STACK;
      4'hB: group = `CAMD_G_FLAG;
      4'hC: begin
        group = `CAMD_G_INT;
        is_wait = 1'b1;
      end
      4'hD: begin
        group = `CAMD_G_INT;
        is_halt = 1'b1;
      end
      default: group = `CAMD_G_INT;
    endcase
  end

endmodule // camd_opcode_table
`default_nettype wire

// ==== hw/camd_ea_unit.v ====
/*
  Effective-address unit: index plus offset or pointer, and program
  counter plus signed relative offset.
  Assumes operands are held stable by the decoder during use.
*/
`timescale 1ns/1ps
`default_nettype none
`include "camd_consts.vh"

module camd_ea_unit (
  // operands
  input wire [7:0] index_val,
  input wire [15:0] base_val,
  input wire use_index,
  input wire [15:0] next_pc,
  input wire [7:0] rel_offset,
  // results
  output wire [15:0] ea,
  output wire [15:0] rel_target
);

  wire [15:0] idx_ext = use_index ? {8'h00, index_val} : 16'h0000;

  // short forms carry into bit 8 naturally in a 16-bit adder
  assign ea = base_val + idx_ext; // RL5 RL7 RL11
  assign rel_target = next_pc + {{8{rel_offset[7]}}, rel_offset}; // RL14 RL25

endmodule // camd_ea_unit
`default_nettype wire

// ==== hw/camd_decoder.v ====
/*
  Instruction fetch and addressing-mode decoder for an 8-bit core.
  Fetches prebyte, opcode and operand bytes, reads pointers from memory,
  and presents effective address, length, group and mode.
  Assumes program memory answers a read in the cycle after mem_rd with
  mem_rdata; index registers come from the core on the same clock.
// Summary of operation
// RL1 - inherent: one byte, no operands fetched
// RL2 - immediate: opcode plus one operand byte
// RL3 - short direct: one address byte, 00-FF
// RL4 - long direct: two address bytes, 64K
// RL5 - indexed address is index plus offset
// RL6 - no-offset indexed: no byte, index alone
// RL7 - short indexed: one byte, carry to bit 8
// RL8 - long indexed: two-byte offset plus index
// RL9 - indirect: operand address read from memory
// RL10 - indirect: one pointer byte, byte/word pointer
// RL11 - indirect indexed: pointer plus index register
// RL12 - indirect indexed short to 1FE, long 64K
// RL13 - some groups allow short variants only
// RL14 - relative adds signed 8-bit offset to PC
// RL15 - relative indirect reads offset from memory
// RL16 - 63 instructions in thirteen groups
// RL17 - length one to four bytes
// RL18 - three prebytes alter following opcode
// RL19 - prebyte 90 selects second index
// RL20 - prebyte 92 selects indirect forms
// RL21 - prebyte 91 indirect indexed with second index
// RL22 - wait enters wait, halt stops oscillator
// RL23 - undefined byte causes a reset
// RL24 - valid but unsupported combination no reset
// RL25 - offset added to next instruction PC
*/
`timescale 1ns/1ps
`default_nettype none
`include "camd_consts.vh"

module camd_decoder (
  // clock and reset
  input wire clk,
  input wire resetn,
  // program memory
  output reg mem_rd,
  output wire [15:0] mem_addr,
  input wire [7:0] mem_rdata,
  // core side
  input wire start,
  input wire [15:0] pc_in,
  input wire [7:0] index_first,
  input wire [7:0] index_second,
  // decoded result
  output reg dec_valid,
  output reg [15:0] dec_ea_ff,
  output reg [7:0] dec_imm_ff,
  output reg [15:0] dec_next_pc_ff,
  output reg [15:0] dec_branch_pc_ff,
  output reg [2:0] dec_len_ff,
  output reg [3:0] dec_mode_ff,
  output reg [3:0] dec_group_ff,
  output reg [7:0] dec_opcode_ff,
  output reg dec_use_second_ff,
  output reg dec_unsupported_ff,
  output reg illegal_reset,
  output reg [1:0] low_power_ff
);

  // ==========================================================
  // state
  reg [2:0] state_ff, nxt_state;
  reg [15:0] pc_ff, nxt_pc;
  reg [7:0] pre_ff, nxt_pre;
  reg [7:0] opc_ff, nxt_opc;
  reg [15:0] word_ff, nxt_word;
  reg [15:0] ptr_ff, nxt_ptr;
  reg [3:0] mode_ff, nxt_mode;
  reg [2:0] len_ff, nxt_len;
  reg busy_ff, nxt_busy;
  reg [15:0] rd_addr;

  wire [3:0] t_mode;
  wire [3:0] t_group;
  wire t_short_only;
  wire t_wait;
  wire t_halt;
  wire t_legal;
  wire [15:0] ea;
  wire [15:0] rel_target;

  wire is_pre = (mem_rdata == `CAMD_PRE_SECOND_INDEX) ||
                (mem_rdata == `CAMD_PRE_INDIRECT) ||
                (mem_rdata == `CAMD_PRE_SECOND_INDIRECT); // RL18
  wire pre_y = (pre_ff == `CAMD_PRE_SECOND_INDEX) ||
               (pre_ff == `CAMD_PRE_SECOND_INDIRECT); // RL19 RL21

  camd_opcode_table u_table (
    .opcode(state_ff == `CAMD_S_OPC ? mem_rdata : opc_ff),
    .base_mode(t_mode),
    .group(t_group),
    .short_only(t_short_only),
    .is_wait(t_wait),
    .is_halt(t_halt),
    .legal(t_legal)
  );

  // indexed modes and indirect indexed use the index; others the base
  wire mode_indexed = (mode_ff == `CAMD_M_IDX_0) ||
                      (mode_ff == `CAMD_M_IDX_S) ||
                      (mode_ff == `CAMD_M_IDX_L) ||
                      (mode_ff == `CAMD_M_IIX_S) ||
                      (mode_ff == `CAMD_M_IIX_L);
  wire mode_ind = (mode_ff == `CAMD_M_IND_S) ||
                  (mode_ff == `CAMD_M_IND_L) ||
                  (mode_ff == `CAMD_M_IIX_S) ||
                  (mode_ff == `CAMD_M_IIX_L);
  wire [15:0] base_val = mode_ind ? ptr_ff : word_ff; // RL9
  wire [7:0] rel_off = (mode_ff == `CAMD_M_REL_I) ? ptr_ff[7:0] :
                       word_ff[7:0]; // RL15

  camd_ea_unit u_ea (
    .index_val(pre_y ? index_second : index_first),
    .base_val(base_val),
    .use_index(mode_indexed),
    .next_pc(pc_ff),
    .rel_offset(rel_off),
    .ea(ea),
    .rel_target(rel_target)
  );

  assign mem_addr = rd_addr;

  // ==========================================================
  // prebyte rewrite of the base mode
  function [3:0] apply_pre;
    input [7:0] pre;
    input [3:0] m;
    begin
      apply_pre = m;
      if (pre == `CAMD_PRE_INDIRECT) begin // RL20
        case (m)
          `CAMD_M_DIR_S: apply_pre = `CAMD_M_IND_S;
          `CAMD_M_DIR_L: apply_pre = `CAMD_M_IND_L;
          `CAMD_M_IDX_S: apply_pre = `CAMD_M_IIX_S;
          `CAMD_M_IDX_L: apply_pre = `CAMD_M_IIX_L;
          `CAMD_M_REL_D: apply_pre = `CAMD_M_REL_I;
          default: apply_pre = m;
        endcase
      end else if (pre == `CAMD_PRE_SECOND_INDIRECT) begin // RL21
        case (m)
          `CAMD_M_IDX_S: apply_pre = `CAMD_M_IIX_S;
          `CAMD_M_IDX_L: apply_pre = `CAMD_M_IIX_L;
          default: apply_pre = m;
        endcase
      end
    end
  endfunction

  // bytes after the opcode per mode
  function [1:0] operand_bytes;
    input [3:0] m;
    begin
      case (m)
        `CAMD_M_INH, `CAMD_M_IDX_0: operand_bytes = 2'd0; // RL1 RL6
        `CAMD_M_DIR_L, `CAMD_M_IDX_L: operand_bytes = 2'd2; // RL4 RL8
        default: operand_bytes = 2'd1; // RL2 RL3 RL7 RL10 RL12
      endcase
    end
  endfunction

  wire [3:0] eff_mode = apply_pre(pre_ff, t_mode);
  wire long_mode = (eff_mode == `CAMD_M_DIR_L) ||
                   (eff_mode == `CAMD_M_IDX_L) ||
                   (eff_mode == `CAMD_M_IND_L) ||
                   (eff_mode == `CAMD_M_IIX_L);
  // 92 or 91 prebyte that changed no mode is an unsupported pair, not illegal
  wire pre_noop = (pre_ff != 8'h00) && (pre_ff != `CAMD_PRE_SECOND_INDEX) &&
                  (eff_mode == t_mode);
  wire unsupported = (t_short_only && long_mode) || pre_noop; // RL13 RL24

  // ==========================================================
  // fetch sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_pre = pre_ff;
    nxt_opc = opc_ff;
    nxt_word = word_ff;
    nxt_ptr = ptr_ff;
    nxt_mode = mode_ff;
    nxt_len = len_ff;
    nxt_busy = busy_ff;
    mem_rd = 1'b0;
    rd_addr = pc_ff;
    case (state_ff)
      `CAMD_S_OPC: begin
        if (!busy_ff) begin
          if (start) begin
            mem_rd = 1'b1;
            rd_addr = pc_in;
            nxt_pc = pc_in + 16'h0001;
            nxt_busy = 1'b1;
            nxt_pre = 8'h00;
            nxt_len = 3'h1;
          end
        end else if (is_pre && pre_ff == 8'h00) begin
          nxt_pre = mem_rdata; // RL18
          mem_rd = 1'b1;
          nxt_pc = pc_ff + 16'h0001;
          nxt_len = len_ff + 3'h1;
        end else if (!t_legal) begin
          nxt_busy = 1'b0; // RL23
        end else begin
          nxt_opc = mem_rdata;
          nxt_mode = eff_mode;
          nxt_word = 16'h0000;
          if (operand_bytes(eff_mode) == 2'd0) begin
            nxt_state = `CAMD_S_DONE; // RL1
          end else begin
            mem_rd = 1'b1;
            nxt_pc = pc_ff + 16'h0001;
            nxt_len = len_ff + 3'h1;
            nxt_state = (operand_bytes(eff_mode) == 2'd2) ?
                        `CAMD_S_OP2 : `CAMD_S_OP1;
          end
        end
      end
      `CAMD_S_OP2: begin
        nxt_word = {mem_rdata, 8'h00}; // RL4 RL8
        mem_rd = 1'b1;
        nxt_pc = pc_ff + 16'h0001;
        nxt_len = len_ff + 3'h1; // RL17
        nxt_state = `CAMD_S_OP1;
      end
      `CAMD_S_OP1: begin
        nxt_word = {word_ff[15:8], mem_rdata};
        if (mode_ind || mode_ff == `CAMD_M_REL_I) begin
          mem_rd = 1'b1; // RL9
          rd_addr = {8'h00, mem_rdata};
          nxt_state = `CAMD_S_PTR1;
        end else begin
          nxt_state = `CAMD_S_DONE;
        end
      end
      `CAMD_S_PTR1: begin
        if (mode_ff == `CAMD_M_IND_L || mode_ff == `CAMD_M_IIX_L) begin
          nxt_ptr = {mem_rdata, 8'h00}; // RL10 RL12
          mem_rd = 1'b1;
          rd_addr = word_ff + 16'h0001;
          nxt_state = `CAMD_S_PTR2;
        end else begin
          nxt_ptr = {8'h00, mem_rdata};
          nxt_state = `CAMD_S_DONE;
        end
      end
      `CAMD_S_PTR2: begin
        nxt_ptr = {ptr_ff[15:8], mem_rdata};
        nxt_state = `CAMD_S_DONE;
      end
      `CAMD_S_DONE: begin
        nxt_state = `CAMD_S_OPC;
        nxt_busy = 1'b0;
      end
      default: begin
        nxt_state = `CAMD_S_OPC;
        nxt_busy = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // registers and result capture
  always @(posedge clk) begin
    if (!resetn) begin
      state_ff <= `CAMD_S_OPC;
      pc_ff <= 16'h0000;
      pre_ff <= 8'h00;
      opc_ff <= 8'h00;
      word_ff <= 16'h0000;
      ptr_ff <= 16'h0000;
      mode_ff <= `CAMD_M_INH;
      len_ff <= 3'h0;
      busy_ff <= 1'b0;
      dec_valid <= 1'b0;
      dec_ea_ff <= 16'h0000;
      dec_imm_ff <= 8'h00;
      dec_next_pc_ff <= 16'h0000;
      dec_branch_pc_ff <= 16'h0000;
      dec_len_ff <= 3'h0;
      dec_mode_ff <= `CAMD_M_INH;
      dec_group_ff <= `CAMD_G_LOAD;
      dec_opcode_ff <= 8'h00;
      dec_use_second_ff <= 1'b0;
      dec_unsupported_ff <= 1'b0;
      illegal_reset <= 1'b0;
      low_power_ff <= `CAMD_LOW_POWER_NONE;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      pre_ff <= nxt_pre;
      opc_ff <= nxt_opc;
      word_ff <= nxt_word;
      ptr_ff <= nxt_ptr;
      mode_ff <= nxt_mode;
      len_ff <= nxt_len;
      busy_ff <= nxt_busy;
      dec_valid <= 1'b0;
      // one-cycle pulse; core applies the system reset
      illegal_reset <= busy_ff && (state_ff == `CAMD_S_OPC) &&
                       !(is_pre && pre_ff == 8'h00) && !t_legal; // RL23
      if (state_ff == `CAMD_S_DONE) begin
        dec_valid <= 1'b1;
        dec_ea_ff <= ea; // RL5 RL6
        dec_imm_ff <= word_ff[7:0]; // RL2
        dec_next_pc_ff <= pc_ff;
        dec_branch_pc_ff <= rel_target; // RL14 RL25
        dec_len_ff <= len_ff; // RL17
        dec_mode_ff <= mode_ff;
        dec_group_ff <= t_group; // RL16
        dec_opcode_ff <= opc_ff;
        dec_use_second_ff <= pre_y; // RL19
        // table now looks at opc_ff, so eff_mode equals mode_ff here
        dec_unsupported_ff <= unsupported; // RL13 RL24
        if (t_wait) begin
          low_power_ff <= `CAMD_LOW_POWER_WAIT; // RL22
        end else if (t_halt) begin
          low_power_ff <= `CAMD_LOW_POWER_HALT; // RL22
        end
      end else if (start) begin
        low_power_ff <= `CAMD_LOW_POWER_NONE;
      end
    end
  end

endmodule // camd_decoder
`default_nettype wire

// ==== sim/camd_prog_mem.sv ====
/*
  Program memory model for the addressing-mode decoder bench.
  Assumes one read per cycle, answered at the next clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module camd_prog_mem (
  // fetch port
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];

  initial begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hA5;
  end

  // no read: flip the bus so a stale byte never looks valid
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
endmodule // camd_prog_mem

`default_nettype wire

// ==== sim/camd_decoder_monitor.sv ====
/*
  Checker for the addressing-mode decoder, bound to its ports.
  Assumes the core holds pc_in and the index registers during a decode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "camd_consts.vh"

module camd_decoder_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fetch and core side
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic start,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] index_first,
  input wire logic [7:0] index_second,
  // results
  input wire logic dec_valid,
  input wire logic [15:0] dec_ea_ff,
  input wire logic [7:0] dec_imm_ff,
  input wire logic [15:0] dec_next_pc_ff,
  input wire logic [15:0] dec_branch_pc_ff,
  input wire logic [2:0] dec_len_ff,
  input wire logic [3:0] dec_mode_ff,
  input wire logic [7:0] dec_opcode_ff,
  input wire logic dec_use_second_ff,
  input wire logic dec_unsupported_ff,
  input wire logic illegal_reset,
  input wire logic [1:0] low_power_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire [7:0] ix = dec_use_second_ff ? index_second : index_first;
  wire ok = dec_valid && !dec_unsupported_ff;
  wire [2:0] us = {2'b00, dec_use_second_ff};
  wire [15:0] rel = {{8{dec_imm_ff[7]}}, dec_imm_ff};

  // ==========================================================
  // assertions
  property p_fetch_start;
    $rose(start) |-> mem_rd && mem_addr == pc_in;
  endproperty
  a_fetch_start: assert property (p_fetch_start) else $error("no fetch");
  property p_inh_len;
    ok && dec_mode_ff == `CAMD_M_INH |-> dec_len_ff == 3'h1 + us;
  endproperty
  a_inh_len: assert property (p_inh_len) else $error("inherent length");
  property p_dir_short;
    ok && dec_mode_ff == `CAMD_M_DIR_S |-> dec_ea_ff[15:8] == 8'h00;
  endproperty
  a_dir_short: assert property (p_dir_short) else $error("short direct");
  property p_idx_none;
    ok && dec_mode_ff == `CAMD_M_IDX_0 |-> dec_ea_ff == {8'h00, ix};
  endproperty
  a_idx_none: assert property (p_idx_none) else $error("no-offset idx");
  property p_idx_short;
    ok && dec_mode_ff == `CAMD_M_IDX_S |-> dec_ea_ff - ix <= 16'h00FF;
  endproperty
  a_idx_short: assert property (p_idx_short) else $error("short idx");
  property p_ind_len;
    ok && dec_mode_ff inside {[`CAMD_M_IND_S:`CAMD_M_IIX_L], `CAMD_M_REL_I}
      |-> dec_len_ff == 3'h3;
  endproperty
  a_ind_len: assert property (p_ind_len) else $error("indirect length");
  property p_rel_target;
    ok && dec_mode_ff == `CAMD_M_REL_D |-> dec_branch_pc_ff ==
      dec_next_pc_ff + rel && dec_next_pc_ff == pc_in + dec_len_ff;
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative");
  property p_illegal_pulse;
    illegal_reset |-> !dec_valid ##1 !illegal_reset;
  endproperty
  a_illegal_pulse: assert property (p_illegal_pulse) else $error("ill");
  property p_low_power;
    ok && dec_mode_ff == `CAMD_M_INH && dec_opcode_ff[7:1] == 7'h06 |->
      low_power_ff == (dec_opcode_ff[0] ? 2'h2 : 2'h1);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power");

  // ==========================================================
  // covers
  cover property (ok && dec_mode_ff == `CAMD_M_IIX_L);
  cover property (illegal_reset);
  cover property (dec_valid && dec_unsupported_ff);
  cover property (dec_valid && low_power_ff == 2'h2);
endmodule // camd_decoder_monitor

bind camd_decoder camd_decoder_monitor MON (.clk(clk), .resetn(resetn),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .start(start), .pc_in(pc_in),
  .index_first(index_first), .index_second(index_second),
  .dec_valid(dec_valid), .dec_ea_ff(dec_ea_ff), .dec_imm_ff(dec_imm_ff),
  .dec_next_pc_ff(dec_next_pc_ff), .dec_branch_pc_ff(dec_branch_pc_ff),
  .dec_len_ff(dec_len_ff), .dec_mode_ff(dec_mode_ff),
  .dec_opcode_ff(dec_opcode_ff), .dec_use_second_ff(dec_use_second_ff),
  .dec_unsupported_ff(dec_unsupported_ff), .illegal_reset(illegal_reset),
  .low_power_ff(low_power_ff));

`default_nettype wire

// ==== sim/cpu_addressing_mode_decoder_test.sv ====
/*
  Self-checking bench for the addressing-mode decoder.
  Assumes the program memory model answers every fetch next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "camd_consts.vh"

module cpu_addressing_mode_decoder_test;
  logic clk = 1'b0, resetn = 1'b0, start = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0] index_first = 8'h00, index_second = 8'h00;
  logic mem_rd, dec_valid, dec_use_second_ff, dec_unsupported_ff;
  logic illegal_reset;
  logic [15:0] mem_addr, dec_ea_ff, dec_next_pc_ff, dec_branch_pc_ff;
  logic [7:0] mem_rdata, dec_imm_ff, dec_opcode_ff;
  logic [2:0] dec_len_ff;
  logic [3:0] dec_mode_ff, dec_group_ff;
  logic [1:0] low_power_ff;
  int seed = 32'h5d3c, num_errors = 0, n_checks = 0, cycles = 0;
  logic [3:0] btbl [0:7] = '{`CAMD_M_INH, `CAMD_M_IMM, `CAMD_M_DIR_S,
    `CAMD_M_DIR_L, `CAMD_M_IDX_0, `CAMD_M_IDX_S, `CAMD_M_IDX_L, `CAMD_M_REL_D};
  logic [3:0] itbl [0:7] = '{`CAMD_M_BAD, `CAMD_M_BAD, `CAMD_M_IND_S,
    `CAMD_M_IND_L, `CAMD_M_BAD, `CAMD_M_IIX_S, `CAMD_M_IIX_L, `CAMD_M_REL_I};
  logic [3:0] gtbl [0:15] = '{`CAMD_G_LOAD, `CAMD_G_CMP, `CAMD_G_LOGIC,
    `CAMD_G_ARITH, `CAMD_G_INCDEC, `CAMD_G_BIT, `CAMD_G_BTJ, `CAMD_G_SHIFT,
    `CAMD_G_JUMP, `CAMD_G_COND, `CAMD_G_STACK, `CAMD_G_FLAG, `CAMD_G_INT,
    `CAMD_G_INT, `CAMD_G_INT, `CAMD_G_INT};
  int klen [0:7] = '{0, 1, 1, 2, 0, 1, 2, 1};
  logic [7:0] pres [0:2] = '{8'h90, 8'h91, 8'h92};

  always #20 clk = ~clk;

  camd_decoder DUT (.clk(clk), .resetn(resetn), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .start(start),
    .pc_in(pc_in), .index_first(index_first), .index_second(index_second),
    .dec_valid(dec_valid), .dec_ea_ff(dec_ea_ff), .dec_imm_ff(dec_imm_ff),
    .dec_next_pc_ff(dec_next_pc_ff), .dec_branch_pc_ff(dec_branch_pc_ff),
    .dec_len_ff(dec_len_ff), .dec_mode_ff(dec_mode_ff),
    .dec_group_ff(dec_group_ff), .dec_opcode_ff(dec_opcode_ff),
    .dec_use_second_ff(dec_use_second_ff),
    .dec_unsupported_ff(dec_unsupported_ff),
    .illegal_reset(illegal_reset), .low_power_ff(low_power_ff));
  camd_prog_mem MEM (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));

  // ==========================================================
  // helpers
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] pick(input logic [2:0] h, input logic [7:0] r);
    logic [3:0] l;
    l = (h == 1 || h == 3 || h == 6) ? {2'b00, r[1:0]} :
      (h == 7) ? {3'b100, r[0]} : 4'(r % 9);
    return {1'b0, h, l};
  endfunction

  // one instruction: place bytes, start, wait, compare
  task automatic run(input logic [7:0] pre, opc, b1, xv);
    logic [7:0] b2, p1, p2, ix, off;
    logic [15:0] pc, ea, nx;
    logic [3:0] m;
    logic [2:0] h;
    logic ind, unsup, sec, lng;
    int len, lat, cnt, nptr;
    h = opc[6:4];
    b2 = 8'($random(seed));
    p1 = 8'($random(seed));
    p2 = 8'($random(seed));
    pc = 16'h1000 + 16'($random(seed) & 32'h3FF0);
    sec = pre == 8'h90 || pre == 8'h91;
    ix = sec ? ~xv : xv;
    ind = pre == 8'h91 || pre == 8'h92;
    m = ind ? itbl[h] : btbl[h];
    lng = h == 3 || h == 6;
    unsup = ind && (m == `CAMD_M_BAD || (pre == 8'h91 && h != 5 && h != 6))
      || (lng && opc[3:0] >= 4'h4 && opc[3:0] <= 4'h8);
    nptr = ind ? (lng ? 2 : 1) : 0;
    len = (pre != 8'h00) + 1 + (ind ? 1 : klen[h]);
    lat = len + nptr + 2;
    nx = pc + 16'(len);
    ea = ind ? (lng ? {p1, p2} : {8'h00, p1}) : (lng ? {b1, b2} : {8'h00, b1});
    if (h == 4) ea = 16'h0000;
    if (h >= 4 && h <= 6) ea = ea + {8'h00, ix};
    off = ind ? p1 : b1;
    MEM.mem[pc] = pre;
    MEM.mem[pc + 16'(pre != 8'h00)] = opc;
    MEM.mem[pc + 16'(pre != 8'h00) + 16'h1] = b1;
    MEM.mem[pc + 16'(pre != 8'h00) + 16'h2] = b2;
    MEM.mem[{8'h00, b1}] = p1;
    MEM.mem[{8'h00, b1} + 16'h1] = p2;
    // keep core inputs held while the last result is still checked
    @(negedge clk);
    index_first = xv;
    index_second = ~xv;
    pc_in = pc;
    start = 1'b1;
    cnt = 0;
    do begin
      @(negedge clk);
      start = 1'b0;
      cnt++;
    end while (dec_valid !== 1'b1 && illegal_reset !== 1'b1 && cnt < 20);
    if (opc[7]) begin
      chk_val("illegal_reset", 16'h1, 16'(illegal_reset));
      chk_val("dec_valid", 16'h0, 16'(dec_valid));
    end else begin
      chk_val("dec_valid", 16'h1, 16'(dec_valid));
      chk_val("illegal_reset", 16'h0, 16'(illegal_reset));
      chk_val("unsupported", 16'(unsup), 16'(dec_unsupported_ff));
      if (!unsup) begin
        chk_val("latency", 16'(lat), 16'(cnt));
        chk_val("length", 16'(len), 16'(dec_len_ff));
        chk_val("mode", 16'(m), 16'(dec_mode_ff));
        chk_val("next_pc", nx, dec_next_pc_ff);
        chk_val("group", 16'(gtbl[opc[3:0]]), 16'(dec_group_ff));
        chk_val("use_second", 16'(sec), 16'(dec_use_second_ff));
        if (h >= 2 && h <= 6) chk_val("ea", ea, dec_ea_ff);
        if (h == 7) chk_val("branch", nx + {{8{off[7]}}, off},
          dec_branch_pc_ff);
        if (h == 1) chk_val("imm", 16'(b1), 16'(dec_imm_ff));
        chk_val("low_power", (opc == 8'h0C) ? 16'h1 : (opc == 8'h0D) ?
          16'h2 : 16'h0, 16'(low_power_ff));
      end
    end
  endtask

  // ==========================================================
  // stimulus
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      finish_test;
    end
  end

  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 16; i++) run(8'h00, 8'(i), 8'($random(seed)), 8'h33);
    $display("test inherent_groups done");
    for (int i = 0; i < 120; i++)
      run(8'h00, pick(3'($random(seed)), 8'($random(seed))),
        8'($random(seed)), 8'($random(seed)));
    $display("test random_modes done");
    // every prebyte on every mode column except 90 on the relative column, unsupported pairs too
    for (int r = 0; r < 3; r++)
      for (int p = 0; p < 3; p++)
        for (int h = 0; h < 8; h++)
          if (p != 0 || h != 7) run(pres[p], pick(3'(h), 8'($random(seed))),
            8'($random(seed)), 8'($random(seed)));
    $display("test prebytes done");
    run(8'h00, 8'h50, 8'hFF, 8'hFF);
    run(8'h90, 8'h50, 8'hFF, 8'h00);
    run(8'h92, 8'h50, 8'hFF, 8'hFF);
    run(8'h00, 8'h79, 8'h80, 8'h00);
    run(8'h00, 8'h78, 8'h7F, 8'h00);
    run(8'h00, 8'h34, 8'h12, 8'h00);
    run(8'h92, 8'h67, 8'h20, 8'h05);
    $display("test corners done");
    for (int i = 0; i < 8; i++)
      run(8'h00, 8'hA0 | 8'($random(seed)), 8'h00, 8'h00);
    run(8'h92, 8'hF3, 8'h00, 8'h00);
    run(8'h00, 8'h20, 8'h44, 8'h00);
    $display("test illegal done");
    finish_test;
  end
endmodule // cpu_addressing_mode_decoder_test

`default_nettype wire
